// ---- core/flash_ctrl_pkg.sv ----
package flash_ctrl_pkg;

  // APB register map, byte addresses.
  localparam int unsigned    APB_AW       = 8;
  localparam logic [7:0]     OFF_CTRL     = 8'h00;
  localparam logic [7:0]     OFF_KEY      = 8'h04;
  localparam logic [7:0]     OFF_TABLE_PAGE_REG   = 8'h08;
  localparam logic [7:0]     OFF_EA       = 8'h0c;
  localparam logic [7:0]     OFF_TBLOP    = 8'h10;
  localparam logic [7:0]     OFF_TBLRD    = 8'h14;

  // flash_op_control fields.
  localparam int unsigned    CTRL_WR      = 15;
  localparam int unsigned    CTRL_FLASH_WRITE_ENABLE    = 14;
  localparam int unsigned    CTRL_SEQUENCE_ERROR_FLAG   = 13;
  localparam int unsigned    CTRL_ERASE   = 6;
  localparam logic [15:0]    CTRL_RESET   = 16'h0000;

  // Table operation register fields.
  localparam int unsigned    TOP_HIGH     = 16;
  localparam int unsigned    TOP_BYTE     = 17;
  localparam int unsigned    TOP_READ     = 18;

  localparam logic [7:0]     KEY_FIRST    = 8'h55;
  localparam logic [7:0]     KEY_SECOND   = 8'haa;

  localparam logic [3:0]     OPC_BULK     = 4'hf;
  localparam logic [3:0]     OPC_GEN_SEG  = 4'hd;
  localparam logic [3:0]     OPC_SEC_SEG  = 4'hc;
  localparam logic [3:0]     OPC_WORD     = 4'h3;
  localparam logic [3:0]     OPC_PAGE     = 4'h2;
  localparam logic [3:0]     OPC_ROW      = 4'h1;
  localparam logic [3:0]     OPC_CFG      = 4'h0;

  // Geometry: 64 instructions (192 bytes) per row, 8 rows (1536 bytes) per page.
  localparam int unsigned    ROW_WORDS    = 64;
  localparam int unsigned    PAGE_ROWS    = 8;
  localparam int unsigned    ROW_LSB      = 7;
  localparam int unsigned    PAGE_LSB     = 10;
  localparam logic [5:0]     ROW_LAST     = 6'h3f;

  localparam int unsigned    OP_TIME_US   = 4000;
  localparam int unsigned    CLK_MHZ      = 125;
  localparam int unsigned    OP_CYCLES    = OP_TIME_US * CLK_MHZ;

  typedef enum logic [3:0] {
    FL_NONE, FL_READ, FL_PROG_WORD, FL_PROG_ROW, FL_ERASE_PAGE, FL_ERASE_BULK,
    FL_ERASE_GEN, FL_ERASE_SEC, FL_PROG_CFG, FL_ERASE_CFG, FL_ABORT
  } fl_cmd_e;

  typedef enum logic [1:0] {S_IDLE, S_STREAM, S_ISSUE, S_WAIT} seq_e;
  typedef enum logic [1:0] {K_NONE, K_HALF, K_ARMED} key_e;

  typedef struct packed {
    fl_cmd_e     cmd;
    logic [23:0] addr;
    logic [23:0] wdata;
  } fl_req_s;

endpackage

// ---- core/flash_self_program_controller.sv ----
// Functional notes
// (RULE1) Table address is table_page_reg low byte above the 16-bit effective address.
// (RULE2) Low table accesses reach program word bits 15:0, word or byte mode.
// (RULE3) High table accesses reach program word bits 23:16, word or byte mode.
// (RULE4) Rows hold 64 instructions, 192 bytes; a row is programmed as one unit.
// (RULE5) Page erase clears eight consecutive rows, 512 instructions.
// (RULE6) Pages align on 1536 bytes, rows on 192 bytes, from memory start.
// (RULE7) Software loads the holding buffer sequentially within one 64-word group.
// (RULE8) A full row needs 64 low and 64 high table writes first.
// (RULE9) Buffer-loading table writes touch only the holding buffer, never the array.
// (RULE10) Key register is write-only; 55h then AAh must precede each start.
// (RULE11) Operations last nominally 4 ms; the processor stalls until done.
// (RULE12) Start bit 15 is set by software only and cleared by hardware.
// (RULE13) Write-enable bit 14 allows program and erase; zero inhibits them.
// (RULE14) Sequence-error bit 13 flags improper sequences; zero after normal completion.
// (RULE15) Erase bit 6 picks erase variant when one, program variant when zero.
// (RULE16) With erase, 1111 bulk, 1101 general segment, 1100 secure segment erase.
// (RULE17) 0011 word and 0001 row program without erase; 0010 page erase with.
// (RULE18) Code 0000 programs or erases one configuration byte.
// (RULE19) Codes 1110 and 0100 to 1011 are reserved and start nothing.
// (RULE20) Control bits reset only on power-on reset.
// (RULE21) A dummy low table write latches the page erase target address.
// (RULE22) Software places two no-operations right after setting the start bit.
// (RULE23) Control bits 12 to 7 and 5 to 4 read zero.
// (RULE24) Table page bit 7 selects configuration space, else user space.
// (RULE25) Start without fresh key pair or write-enable sets error, flash untouched.
`timescale 1ns/1ps

module flash_self_program_controller
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned OP_CYC = OP_CYCLES
) (
  // Clock and power-on reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Other device resets
  input  wire logic              warm_rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  // Flash array macro
  output fl_req_s                fl_req,
  input  wire logic [23:0]       fl_rdata,
  // Processor stall
  output logic                   cpu_stall
);

  localparam int unsigned TW = $clog2(OP_CYC + 1);
  localparam logic [TW-1:0] T_LAST = TW'(OP_CYC - 1);

  initial begin
    if (OP_CYC < 1 || OP_CYC > 32'h00ffffff) begin
      $error("OP_CYC out of range");
    end
  end

  typedef struct packed {
    seq_e              seq;
    key_e              key;
    logic              wr;
    logic              flash_write_enable;
    logic              sequence_error_flag;
    logic              erase;
    logic [3:0]        opsel;
    logic [7:0]        table_page_reg;
    logic [15:0]       ea;
    logic [23:0]       tgt;
    logic [5:0]        cnt;
    logic [TW-1:0]     tmr;
    fl_cmd_e           run;
    logic [63:0][23:0] hbuf;
    logic [23:0]       rdat;
    logic              rd_pend;
    logic [2:0]        rdmode;
    fl_req_s           fl;
    logic              stall;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } st_s;

  st_s s_q;
  st_s s_d;

  function automatic fl_cmd_e decode_op(input logic [3:0] op, input logic er);
    fl_cmd_e c;
    c = FL_NONE;
    if (op == OPC_BULK && er) begin // [RULE16] [RULE15]
      c = FL_ERASE_BULK;
    end else if (op == OPC_GEN_SEG && er) begin // [RULE16]
      c = FL_ERASE_GEN;
    end else if (op == OPC_SEC_SEG && er) begin // [RULE16]
      c = FL_ERASE_SEC;
    end else if (op == OPC_WORD && !er) begin // [RULE17]
      c = FL_PROG_WORD;
    end else if (op == OPC_ROW && !er) begin // [RULE17] [RULE4]
      c = FL_PROG_ROW;
    end else if (op == OPC_PAGE && er) begin // [RULE17]
      c = FL_ERASE_PAGE;
    end else if (op == OPC_CFG) begin // [RULE18]
      c = er ? FL_ERASE_CFG : FL_PROG_CFG;
    end
    // Codes 1110 and 0100..1011 fall through as no action. [RULE19]
    return c;
  endfunction

  logic          acc_wr;
  logic          set_try;
  logic [23:0]   taddr;
  logic [5:0]    tidx;
  fl_cmd_e       req_op;

  always_comb begin
    s_d = s_q;
    s_d.fl.cmd = FL_NONE;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    taddr = {s_q.table_page_reg, s_q.ea}; // [RULE1] [RULE24]
    tidx = taddr[ROW_LSB-1:1];
    acc_wr = psel && penable && s_q.pready && pwrite && !s_q.pslverr;
    set_try = acc_wr && paddr == OFF_CTRL && pwdata[CTRL_WR] && !s_q.wr;
    req_op = decode_op(pwdata[3:0], pwdata[CTRL_ERASE]);

    // Read data returns in the same cycle as the array read strobe.
    s_d.rd_pend = 1'b0;
    if (s_q.rd_pend) begin
      if (!s_q.rdmode[0]) begin // [RULE2]
        s_d.rdat = {8'h00, s_q.rdmode[1] ? {8'h00, (s_q.rdmode[2] ? fl_rdata[15:8]
                                                      : fl_rdata[7:0])} : fl_rdata[15:0]};
      end else begin // [RULE3]
        s_d.rdat = (s_q.rdmode[1] && s_q.rdmode[2]) ? 24'h000000 : {16'h0000, fl_rdata[23:16]};
      end
    end

    // Accesses wait while an operation runs, which is how the processor stalls. [RULE11]
    if (psel && penable && !s_q.pready && s_q.seq == S_IDLE) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h00000000;
      if (paddr == OFF_CTRL) begin // [RULE23]
        s_d.prdata = {16'h0000, s_q.wr, s_q.flash_write_enable, s_q.sequence_error_flag, 6'h00, s_q.erase, 2'h0,
                      s_q.opsel};
      end else if (paddr == OFF_KEY) begin // [RULE10]
        s_d.prdata = 32'h00000000;
      end else if (paddr == OFF_TABLE_PAGE_REG) begin
        s_d.prdata = {24'h000000, s_q.table_page_reg};
      end else if (paddr == OFF_EA) begin
        s_d.prdata = {16'h0000, s_q.ea};
      end else if (paddr == OFF_TBLOP) begin
        s_d.prdata = 32'h00000000;
      end else if (paddr == OFF_TBLRD) begin
        s_d.prdata = {8'h00, s_q.rdat};
      end else begin
        s_d.pslverr = 1'b1;
      end
    end

    if (acc_wr) begin
      // Any write to a mapped register other than the second key breaks the unlock pair. [RULE10]
      s_d.key = K_NONE;
      if (paddr == OFF_KEY) begin
        if (pwdata[7:0] == KEY_FIRST) begin
          s_d.key = K_HALF;
        end else if (pwdata[7:0] == KEY_SECOND && s_q.key == K_HALF) begin
          s_d.key = K_ARMED;
        end
      end else if (paddr == OFF_CTRL) begin
        s_d.flash_write_enable = pwdata[CTRL_FLASH_WRITE_ENABLE]; // [RULE13]
        s_d.sequence_error_flag = pwdata[CTRL_SEQUENCE_ERROR_FLAG];
        s_d.erase = pwdata[CTRL_ERASE]; // [RULE15]
        s_d.opsel = pwdata[3:0];
        if (set_try) begin
          if (s_q.key != K_ARMED || !pwdata[CTRL_FLASH_WRITE_ENABLE]) begin
            s_d.sequence_error_flag = 1'b1; // [RULE25] [RULE14]
          end else if (req_op != FL_NONE) begin
            s_d.wr = 1'b1; // [RULE12]
            s_d.run = req_op;
            s_d.cnt = 6'h00;
            s_d.seq = (req_op == FL_PROG_ROW) ? S_STREAM : S_ISSUE;
          end
        end
      end else if (paddr == OFF_TABLE_PAGE_REG) begin
        s_d.table_page_reg = pwdata[7:0];
      end else if (paddr == OFF_EA) begin
        s_d.ea = pwdata[15:0];
      end else if (paddr == OFF_TBLOP) begin
        if (pwdata[TOP_READ]) begin
          s_d.fl.cmd = FL_READ;
          // The array is word addressed; bit 0 only picks the byte within the word.
          s_d.fl.addr = {taddr[23:1], 1'b0};
          s_d.rd_pend = 1'b1;
          s_d.rdmode = {taddr[0], pwdata[TOP_BYTE], pwdata[TOP_HIGH]};
        end else if (pwdata[TOP_HIGH]) begin
          // Only the holding buffer is written here. [RULE9] [RULE3]
          if (!pwdata[TOP_BYTE] || !taddr[0]) begin
            s_d.hbuf[tidx][23:16] = pwdata[7:0];
          end
        end else begin
          if (!pwdata[TOP_BYTE]) begin // [RULE2] [RULE9]
            s_d.hbuf[tidx][15:0] = pwdata[15:0];
          end else if (taddr[0]) begin
            s_d.hbuf[tidx][15:8] = pwdata[7:0];
          end else begin
            s_d.hbuf[tidx][7:0] = pwdata[7:0];
          end
          s_d.tgt = taddr; // [RULE21]
        end
      end
    end

    case (s_q.seq)
      S_STREAM: begin
        // One array write per buffered word, row-aligned. [RULE4] [RULE6]
        s_d.fl.cmd = FL_PROG_ROW;
        s_d.fl.addr = {s_q.tgt[23:ROW_LSB], s_q.cnt, 1'b0};
        s_d.fl.wdata = s_q.hbuf[s_q.cnt];
        s_d.cnt = s_q.cnt + 6'h01;
        if (s_q.cnt == ROW_LAST) begin
          s_d.seq = S_WAIT;
          s_d.tmr = '0;
        end
      end
      S_ISSUE: begin
        s_d.fl.cmd = s_q.run;
        s_d.fl.addr = s_q.tgt;
        if (s_q.run == FL_ERASE_PAGE) begin // [RULE5] [RULE6] [RULE21]
          s_d.fl.addr = {s_q.tgt[23:PAGE_LSB], {PAGE_LSB{1'b0}}};
        end
        s_d.fl.wdata = s_q.hbuf[s_q.tgt[ROW_LSB-1:1]];
        s_d.seq = S_WAIT;
        s_d.tmr = '0;
      end
      S_WAIT: begin
        s_d.tmr = s_q.tmr + TW'(1);
        if (s_q.tmr == T_LAST) begin // [RULE11] [RULE12] [RULE14]
          s_d.seq = S_IDLE;
          s_d.wr = 1'b0;
          s_d.sequence_error_flag = 1'b0;
        end
      end
      default: begin
      end
    endcase

    // A warm reset ends any operation early, which counts as improper termination.
    if (!warm_rst_n) begin
      s_d.key = K_NONE;
      if (s_q.seq != S_IDLE) begin // [RULE14]
        s_d.seq = S_IDLE;
        s_d.wr = 1'b0;
        s_d.sequence_error_flag = 1'b1;
        s_d.fl.cmd = FL_ABORT;
      end
    end
    s_d.stall = (s_d.seq != S_IDLE);
  end

  // Only presetn resets the registers; a warm reset clears only the key state and any running operation. [RULE20]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.wr <= CTRL_RESET[CTRL_WR];
      s_q.seq <= S_IDLE;
      s_q.key <= K_NONE;
      s_q.run <= FL_NONE;
      s_q.fl.cmd <= FL_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign prdata    = s_q.prdata;
  assign fl_req    = s_q.fl;
  assign cpu_stall = s_q.stall;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_start_keyed: assert property ($rose(s_q.wr) |-> $past(s_q.key) == K_ARMED) // [RULE10]
    else $error("start without unlock pair");

  a_start_flash_write_enable: assert property ($rose(s_q.wr) |-> s_q.flash_write_enable) // [RULE13]
    else $error("start with write enable clear");

  a_bad_start: assert property (set_try && s_q.key != K_ARMED // [RULE25]
    |=> s_q.sequence_error_flag && !s_q.wr && s_q.seq == S_IDLE)
    else $error("bad start not flagged");

  a_done_clear: assert property (s_q.seq == S_WAIT && s_q.tmr == T_LAST && warm_rst_n // [RULE14]
    |=> !s_q.wr && !s_q.sequence_error_flag && !cpu_stall)
    else $error("completion did not clear flags");

  a_op_hold: assert property (s_q.seq == S_WAIT && s_q.tmr != T_LAST && warm_rst_n // [RULE11]
    |=> s_q.seq == S_WAIT && s_q.wr && cpu_stall)
    else $error("operation ended early");

  a_busy_wait: assert property (s_q.seq != S_IDLE |=> !pready) // [RULE11]
    else $error("bus answered while busy");

  a_row_end: assert property (s_q.seq == S_STREAM && s_q.cnt == ROW_LAST && warm_rst_n // [RULE4]
    |=> fl_req.cmd == FL_PROG_ROW && fl_req.addr[ROW_LSB-1:0] == 7'h7e ##1 s_q.seq == S_WAIT)
    else $error("row stream length wrong");

  a_page_align: assert property (fl_req.cmd == FL_ERASE_PAGE // [RULE6]
    |-> fl_req.addr[PAGE_LSB-1:0] == 10'h000)
    else $error("page erase not aligned");

  a_rsvd_op: assert property (set_try && (pwdata[3:0] == 4'he || // [RULE19]
    (pwdata[3:0] >= 4'h4 && pwdata[3:0] <= 4'hb)) |=> !s_q.wr)
    else $error("reserved code started");

  a_buf_only: assert property (s_q.seq == S_IDLE && !$past(s_q.seq != S_IDLE) // [RULE9]
    |-> fl_req.cmd inside {FL_NONE, FL_READ})
    else $error("array touched while idle");

  a_cfg_space: assert property (fl_req.cmd == FL_READ // [RULE24]
    |-> fl_req.addr[23] == s_q.table_page_reg[7])
    else $error("space select wrong");

endmodule // flash_self_program_controller

// ---- test/flash_array_model.sv ----
`timescale 1ns/1ps

module flash_array_model
  import flash_ctrl_pkg::*;
(
  // Clock
  input  wire logic        pclk,
  // Array request and read data
  input  wire fl_req_s     fl_req,
  output logic [23:0]      fl_rdata
);
  logic [23:0] mem [logic [23:0]];
  logic [23:0] last_q = 24'h0;
  int          i;

  // Read data stands only while the read request does; otherwise its inverse shows stale use.
  always @(fl_req) begin
    if (fl_req.cmd == FL_READ) begin
      last_q = mem.exists(fl_req.addr) ? mem[fl_req.addr] : 24'hffffff;
      fl_rdata = last_q;
    end else begin
      fl_rdata = ~last_q;
    end
  end

  always @(posedge pclk) begin
    case (fl_req.cmd)
      FL_PROG_WORD, FL_PROG_ROW: mem[fl_req.addr] = fl_req.wdata;
      FL_ERASE_PAGE: for (i = 0; i < 512; i++) begin
        mem.delete({fl_req.addr[23:10], 10'h0} + 24'(2 * i));
      end
      FL_ERASE_BULK: mem.delete();
      default: ;
    endcase
  end
endmodule // flash_array_model

// ---- test/test_flash_self_program_controller.sv ----
`timescale 1ns/1ps

module test_flash_self_program_controller;
  import flash_ctrl_pkg::*;
  localparam int unsigned OPC = 20;
  logic        pclk = 0, presetn = 0, warm_rst_n = 1, err, cpu_stall;
  logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0]  paddr = 0, pg;
  logic [15:0] ea, c;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [23:0] fl_rdata, first_addr, first_wdata, d, w [64];
  fl_req_s     fl_req;
  fl_cmd_e     first_cmd, ec;
  int          bad_count = 0, checks_done = 0, act_n = 0, stall_n = 0, k;

  always #4 pclk = ~pclk;

  flash_self_program_controller #(.OP_CYC(OPC)) i_dut (.pclk(pclk), .presetn(presetn),
    .warm_rst_n(warm_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .fl_req(fl_req),
    .fl_rdata(fl_rdata), .cpu_stall(cpu_stall));
  flash_array_model i_mem (.pclk(pclk), .fl_req(fl_req), .fl_rdata(fl_rdata));

  always @(posedge pclk) begin
    if (cpu_stall === 1'b1) stall_n++;
    if (fl_req.cmd !== FL_NONE && fl_req.cmd !== FL_READ) begin
      if (act_n == 0) begin
        first_cmd = fl_req.cmd;
        first_addr = fl_req.addr;
        first_wdata = fl_req.wdata;
      end
      act_n++;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Holds the request until pready is seen high at a rising edge, giving up after 3000 edges.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 3000);
    rd = prdata;
    err = pslverr;
    if (n >= 3000) chk(32'h1, 32'h0);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic tbl(input logic [15:0] a, input logic [31:0] op);
    apb(1, OFF_TABLE_PAGE_REG, {24'h0, pg});
    apb(1, OFF_EA, {16'h0, a});
    apb(1, OFF_TBLOP, op);
  endtask

  // Key pair, start write, then a control read that waits out the operation.
  task automatic start(input logic [15:0] cv);
    apb(1, OFF_KEY, {24'h0, KEY_FIRST});
    apb(1, OFF_KEY, {24'h0, KEY_SECOND});
    act_n = 0;
    stall_n = 0;
    apb(1, OFF_CTRL, {16'h0, cv});
    apb(0, OFF_CTRL, 32'h0);
  endtask

  function automatic fl_cmd_e exp_cmd(input logic [3:0] op, input logic er);
    case (op)
      4'hf: return er ? FL_ERASE_BULK : FL_NONE;
      4'hd: return er ? FL_ERASE_GEN : FL_NONE;
      4'hc: return er ? FL_ERASE_SEC : FL_NONE;
      4'h3: return er ? FL_NONE : FL_PROG_WORD;
      4'h2: return er ? FL_ERASE_PAGE : FL_NONE;
      4'h1: return er ? FL_NONE : FL_PROG_ROW;
      4'h0: return er ? FL_ERASE_CFG : FL_PROG_CFG;
      default: return FL_NONE;
    endcase
  endfunction

  initial begin
    void'($urandom(32'hd32d));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, OFF_CTRL, 0); chk(rd, 0);
    apb(1, OFF_KEY, 32'h55); apb(0, OFF_KEY, 0); chk(rd, 0);
    apb(0, 8'hfc, 0); chk({31'h0, err}, 1);
    apb(1, OFF_CTRL, 32'h7fff); apb(0, OFF_CTRL, 0); chk(rd, 32'h604f);
    @(posedge pclk) warm_rst_n <= 0;
    @(posedge pclk) warm_rst_n <= 1;
    apb(0, OFF_CTRL, 0); chk(rd, 32'h604f);
    $display("register test done");
    apb(1, OFF_CTRL, 0); act_n = 0;
    apb(1, OFF_CTRL, 32'hc003); apb(0, OFF_CTRL, 0); chk(rd, 32'h6003);
    apb(1, OFF_CTRL, 0); start(16'h8003); chk(rd, 32'h2003);
    apb(1, OFF_CTRL, 0); apb(1, OFF_KEY, 32'h55); apb(1, OFF_EA, 0); apb(1, OFF_KEY, 32'haa);
    apb(1, OFF_CTRL, 32'hc003); apb(0, OFF_CTRL, 0); chk(rd, 32'h6003);
    chk(act_n, 0);
    $display("sequence error test done");
    pg = 8'($urandom) & 8'h7f; ea = 16'($urandom) & 16'hfffe; d = 24'($urandom);
    apb(1, OFF_CTRL, 0); act_n = 0;
    tbl(ea, {16'h0, d[15:0]}); apb(1, OFF_TBLOP, {16'h1, 8'h0, d[23:16]});
    chk(act_n, 0);
    start(16'hc003); chk(rd, 32'h4003);
    chk({first_cmd, first_addr, first_wdata}, {FL_PROG_WORD, pg, ea, d});
    chk(stall_n >= OPC, 1);
    tbl(ea, 32'h40000); apb(0, OFF_TBLRD, 0); chk(rd, {16'h0, d[15:0]});
    tbl(ea, 32'h50000); apb(0, OFF_TBLRD, 0); chk(rd, {24'h0, d[23:16]});
    tbl(ea | 16'h1, 32'h60000); apb(0, OFF_TBLRD, 0); chk(rd, {24'h0, d[15:8]});
    $display("word test done");
    ea = 16'($urandom) & 16'hff80; act_n = 0;
    apb(1, OFF_TABLE_PAGE_REG, {24'h0, pg});
    for (k = 0; k < 64; k++) begin
      w[k] = 24'($urandom);
      apb(1, OFF_EA, {16'h0, ea + 16'(2 * k)});
      apb(1, OFF_TBLOP, {16'h0, w[k][15:0]});
      apb(1, OFF_TBLOP, {16'h1, 8'h0, w[k][23:16]});
    end
    chk(act_n, 0);
    start(16'hc001); chk(act_n, 64);
    chk({first_cmd, first_addr}, {FL_PROG_ROW, pg, ea});
    k = $urandom_range(63);
    tbl(ea + 16'(2 * k), 32'h40000); apb(0, OFF_TBLRD, 0); chk(rd, {16'h0, w[k][15:0]});
    $display("row test done");
    tbl(ea + 16'h22, 32'h0); start(16'hc042);
    chk({first_cmd, first_addr}, {FL_ERASE_PAGE, pg, ea[15:10], 10'h0});
    tbl(ea + 16'(2 * k), 32'h40000); apb(0, OFF_TBLRD, 0); chk(rd, 32'hffff);
    $display("page erase test done");
    pg = 8'h80 | 8'($urandom);
    tbl(16'($urandom), 32'h0);
    for (k = 0; k < 32; k++) begin
      c = 16'hc000 | 16'((k / 16) << 6) | 16'(k % 16);
      ec = exp_cmd(c[3:0], c[6]);
      start(c); chk(rd, {16'h0, c & 16'h7fff});
      chk(act_n == 0 ? FL_NONE : first_cmd, ec);
      chk(act_n, ec == FL_NONE ? 0 : (ec == FL_PROG_ROW ? 64 : 1));
      if (act_n > 0) chk(first_addr[23], 1);
    end
    $display("operation code test done");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    finish_test();
  end
endmodule // test_flash_self_program_controller
